/* File: rtl/backplane_bus_pkg.sv */
// shared constants, types and reset values for the backplane bus interface
package backplane_bus_pkg;

  // system clock
  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 40;

  // bus widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;

  // depth of the read-data buffer
  localparam int unsigned RBUF_DEPTH = 2;

  // read/write line levels
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // levels held on the unused backplane lines
  localparam logic LAST_CYCLE_IDLE = 1'b0;
  localparam logic STANDBY_IDLE = 1'b0;
  localparam logic POWER_FAIL_IDLE = 1'b1;
  localparam logic PARITY_ERROR_IDLE = 1'b1;

  // four system clocks make one bus cycle; q high in 1..2, enable high in 2..3
  typedef enum logic [1:0]
  {
    PH_0 = 2'b00,
    PH_1 = 2'b01,
    PH_2 = 2'b10,
    PH_3 = 2'b11
  } bus_phase_t;

  // processor state code, bit 1 is bus available, bit 0 is bus status
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_IACK = 2'b01,
    ST_SACK = 2'b10,
    ST_HALT = 2'b11
  } proc_state_t;

  // one bus request from the core
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic rw;
    logic [DATA_W-1:0] wdata;
  } bus_cmd_t;

  // pin inputs after synchronisation
  typedef struct packed
  {
    logic bus_req_n;
    logic irq_n;
    logic fast_interrupt_request_n_n;
    logic [DATA_W-1:0] data;
  } pin_in_t;

  localparam pin_in_t PIN_IN_RESET = '{bus_req_n: 1'b1, irq_n: 1'b1, fast_interrupt_request_n_n: 1'b1,
                                       data: 8'h00};

  // complete state of the bus interface
  typedef struct packed
  {
    bus_phase_t phase;
    logic e;
    logic q;
    logic valid_address_qualifier;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic granted;
    logic rd_pend;
    logic irq_latched;
    logic irq_take;
    logic fast_interrupt_request_n_take;
    proc_state_t proc_state;
  } bif_state_t;

  localparam bif_state_t BIF_RESET = '{phase: PH_0, e: 1'b0, q: 1'b0, valid_address_qualifier: 1'b0,
                                       rw: RW_READ, addr: 16'h0000, wdata: 8'h00,
                                       data_oe: 1'b0, granted: 1'b0, rd_pend: 1'b0,
                                       irq_latched: 1'b0, irq_take: 1'b0,
                                       fast_interrupt_request_n_take: 1'b0, proc_state: ST_RUN};

endpackage : backplane_bus_pkg

/* File: rtl/pin_synchronizer.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_synchronizer #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t sync_r;
  sync_state_t sync_nxt;

  always_comb
  begin
    sync_nxt.meta = i_async;
    sync_nxt.stable = sync_r.meta;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      sync_r <= {RESET_VAL, RESET_VAL};
    end
    else
    begin
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r.stable;

endmodule : pin_synchronizer

`default_nettype wire

/* File: rtl/two_entry_buffer.sv */
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // fill level
  output logic o_empty,
  output logic o_full
);

  typedef struct packed
  {
    logic [WIDTH-1:0] slot1;
    logic [WIDTH-1:0] slot0;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_state_t;

  localparam logic [1:0] COUNT_FULL = 2'h2;

  buf_state_t buf_r;
  buf_state_t buf_nxt;
  logic push;
  logic pop;

  assign o_full = (buf_r.count == COUNT_FULL);
  assign o_empty = (buf_r.count == 2'h0);
  assign o_in_ready = !o_full;
  assign o_out_valid = !o_empty;
  assign o_out_data = buf_r.rd_ptr ? buf_r.slot1 : buf_r.slot0;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    buf_nxt = buf_r;
    if (push)
    begin
      if (buf_r.wr_ptr)
      begin
        buf_nxt.slot1 = i_in_data;
      end
      else
      begin
        buf_nxt.slot0 = i_in_data;
      end
      buf_nxt.wr_ptr = !buf_r.wr_ptr;
    end
    if (pop)
    begin
      buf_nxt.rd_ptr = !buf_r.rd_ptr;
    end
    case ({push, pop})
      2'b10: buf_nxt.count = buf_r.count + 2'h1;
      2'b01: buf_nxt.count = buf_r.count - 2'h1;
      default: buf_nxt.count = buf_r.count;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      buf_r <= '0;
    end
    else
    begin
      buf_r <= buf_nxt;
    end
  end

endmodule : two_entry_buffer

`default_nettype wire

/* File: rtl/backplane_bus_if.sv */
// processor-module side of the backplane bus: clocks, cycles, release, interrupts
`timescale 1ns/100ps
`default_nettype none

module backplane_bus_if
  import backplane_bus_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,

  // core command port
  input wire logic i_cmd_valid,
  input wire backplane_bus_pkg::bus_cmd_t i_cmd,
  output logic o_cmd_ready,

  // core read data port
  output logic o_rdata_valid,
  output logic [backplane_bus_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_rdata_ready,

  // core status and interrupt handshake
  input wire backplane_bus_pkg::proc_state_t i_core_state,
  input wire logic i_instr_done,
  input wire logic i_irq_mask,
  input wire logic i_fast_interrupt_request_n_mask,
  output logic o_irq_take,
  output logic o_fast_interrupt_request_n_take,
  output logic o_bus_released,

  // bus clocks
  output logic o_bus_enable_clock,
  output logic o_quadrature_clock,
  output logic o_free_running_memory_clock,

  // address and control pins
  output logic o_valid_address_qualifier,
  output logic [backplane_bus_pkg::ADDR_W-1:0] o_address,
  output logic o_address_oe,
  output logic o_read_write,
  output logic o_read_write_oe,

  // shared data lines
  input wire logic [backplane_bus_pkg::DATA_W-1:0] i_data_line,
  output logic [backplane_bus_pkg::DATA_W-1:0] o_data_line,
  output logic o_data_line_oe,

  // bus arbitration and state
  input wire logic i_external_bus_request_n,
  output logic o_bus_grant_out,
  output logic [1:0] o_processor_state_bit,

  // interrupt request pins
  input wire logic i_fast_interrupt_request_n,
  input wire logic i_interrupt_request_n,

  // unused backplane lines
  output logic o_last_cycle_marker,
  output logic o_standby_line,
  output logic o_power_fail_line,
  output logic o_parity_error_line
);

  import backplane_bus_pkg::*;

  bif_state_t s_r;
  bif_state_t s_nxt;
  pin_in_t pins_raw;
  pin_in_t pins;

  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_empty;
  logic read_in_flight;
  logic cmd_take;

  // every asynchronous pin passes two flops first
  assign pins_raw.bus_req_n = i_external_bus_request_n;
  assign pins_raw.irq_n = i_interrupt_request_n;
  assign pins_raw.fast_interrupt_request_n_n = i_fast_interrupt_request_n;
  assign pins_raw.data = i_data_line;

  pin_synchronizer #(
    .WIDTH($bits(pin_in_t)),
    .RESET_VAL(PIN_IN_RESET)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // read data is pushed two clocks after enable falls, once sync has settled
  assign buf_in_valid = s_r.rd_pend && (s_r.phase == PH_1);

  two_entry_buffer #(
    .WIDTH(DATA_W)
  ) u_read_buffer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in_valid(buf_in_valid),
    .i_in_data(pins.data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_rdata_valid),
    .o_out_data(o_rdata),
    .i_out_ready(i_rdata_ready),
    .o_empty(buf_empty),
    .o_full()
  );

  // a read now on the bus still needs a slot, so a new read must see room for two
  assign read_in_flight = s_r.valid_address_qualifier && (s_r.rw == RW_READ) && !s_r.granted;

  // commands start only at a cycle boundary and never while released
  always_comb
  begin
    o_cmd_ready = 1'b0;
    // one command per bus cycle, so refuse at every other phase
    if (s_r.phase == PH_3)
    begin
      if (!s_r.granted && pins.bus_req_n)
      begin
        o_cmd_ready = buf_in_ready && (!read_in_flight || buf_empty);
      end
    end
  end

  assign cmd_take = i_cmd_valid && o_cmd_ready;

  always_comb
  begin
    s_nxt = s_r;

    // release follows the synchronised request level
    if (!pins.bus_req_n)
    begin
      s_nxt.granted = 1'b1;
    end
    else
    begin
      s_nxt.granted = 1'b0;
    end

    // phase counter never stops, so the clocks run ungated
    // q leads e by one system clock
    case (s_r.phase)
      PH_0:
      begin
        s_nxt.phase = PH_1;
        s_nxt.q = 1'b1;
        s_nxt.e = 1'b0;
      end
      PH_1:
      begin
        s_nxt.phase = PH_2;
        s_nxt.q = 1'b1;
        s_nxt.e = 1'b1;
      end
      PH_2:
      begin
        s_nxt.phase = PH_3;
        s_nxt.q = 1'b0;
        s_nxt.e = 1'b1;
      end
      PH_3:
      begin
        s_nxt.phase = PH_0;
        s_nxt.q = 1'b0;
        s_nxt.e = 1'b0;
      end
      default:
      begin
        s_nxt.phase = PH_0;
        s_nxt.q = 1'b0;
        s_nxt.e = 1'b0;
      end
    endcase

    // cycle boundary: load the next bus cycle
    s_nxt.irq_take = 1'b0;
    if (s_r.phase == PH_3)
    begin
      if (cmd_take)
      begin
        s_nxt.addr = i_cmd.addr;
        s_nxt.rw = i_cmd.rw;
        s_nxt.wdata = i_cmd.wdata;
        s_nxt.valid_address_qualifier = 1'b1;
      end
      else
      begin
        s_nxt.valid_address_qualifier = 1'b0;
        s_nxt.rw = RW_READ;
      end
      // selected module drove data during enable; capture it
      s_nxt.rd_pend = read_in_flight;
      // request latched during q acts in the following cycle
      if (s_r.irq_latched && !i_irq_mask)
      begin
        s_nxt.irq_take = 1'b1;
      end
    end

    // the captured byte has gone into the buffer
    if (buf_in_valid)
    begin
      s_nxt.rd_pend = 1'b0;
    end

    // interrupt level sampled each cycle while q is high
    if (s_r.q)
    begin
      s_nxt.irq_latched = !pins.irq_n;
    end

    // a released bus carries no valid address
    // a cycle cut by a release is dropped, not repeated
    if (s_nxt.granted)
    begin
      s_nxt.valid_address_qualifier = 1'b0;
    end

    // write data only in the enable-high half of a write cycle
    s_nxt.data_oe = 1'b0;
    if (s_nxt.valid_address_qualifier && (s_nxt.rw == RW_WRITE) && !s_nxt.granted)
    begin
      s_nxt.data_oe = s_nxt.e;
    end

    // fast interrupt follows the level, checked at instruction end
    s_nxt.fast_interrupt_request_n_take = 1'b0;
    if (i_instr_done && !i_fast_interrupt_request_n_mask)
    begin
      s_nxt.fast_interrupt_request_n_take = !pins.fast_interrupt_request_n_n;
    end

    // release overrides the core's state code
    if (s_nxt.granted)
    begin
      s_nxt.proc_state = ST_HALT;
    end
    else
    begin
      s_nxt.proc_state = i_core_state;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      s_r <= BIF_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // clocks
  assign o_bus_enable_clock = s_r.e;
  assign o_quadrature_clock = s_r.q;
  assign o_free_running_memory_clock = s_r.e;

  // address, control and data
  assign o_valid_address_qualifier = s_r.valid_address_qualifier;
  assign o_address = s_r.addr;
  assign o_address_oe = !s_r.granted;
  assign o_read_write = s_r.rw;
  assign o_read_write_oe = !s_r.granted;
  assign o_data_line = s_r.wdata;
  assign o_data_line_oe = s_r.data_oe;

  // arbitration and state
  assign o_bus_grant_out = s_r.granted;
  assign o_bus_released = s_r.granted;
  assign o_processor_state_bit = s_r.proc_state;

  // core interrupt handshake
  assign o_irq_take = s_r.irq_take;
  assign o_fast_interrupt_request_n_take = s_r.fast_interrupt_request_n_take;

  // unused lines held at their idle levels
  assign o_last_cycle_marker = LAST_CYCLE_IDLE;
  assign o_standby_line = STANDBY_IDLE;
  assign o_power_fail_line = POWER_FAIL_IDLE;
  assign o_parity_error_line = PARITY_ERROR_IDLE;

endmodule : backplane_bus_if

`default_nettype wire

/* File: verif/backplane_bus_sva.sv */
// assertion checker for the backplane bus interface
`timescale 1ns/100ps
`default_nettype none
module backplane_bus_sva
  import backplane_bus_pkg::*;
(
  // watched ports
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_instr_done,
  input wire logic i_irq_mask,
  input wire logic i_fast_interrupt_request_n_mask,
  input wire logic i_external_bus_request_n,
  input wire logic o_irq_take,
  input wire logic o_fast_interrupt_request_n_take,
  input wire logic o_bus_enable_clock,
  input wire logic o_quadrature_clock,
  input wire logic o_free_running_memory_clock,
  input wire logic o_valid_address_qualifier,
  input wire logic o_address_oe,
  input wire logic o_read_write_oe,
  input wire logic o_data_line_oe,
  input wire logic o_bus_grant_out,
  input wire logic [1:0] o_processor_state_bit,
  input wire logic o_last_cycle_marker,
  input wire logic o_standby_line,
  input wire logic o_power_fail_line,
  input wire logic o_parity_error_line
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  mem_clock_a:
    assert property (o_free_running_memory_clock == o_bus_enable_clock) else $error("mem clk");
  data_in_enable_a:
    assert property (o_data_line_oe |-> o_bus_enable_clock) else $error("data outside enable");
  release_float_a:
    assert property (o_bus_grant_out |-> !o_address_oe && !o_read_write_oe && !o_data_line_oe)
      else $error("lines not floated");
  grant_on_a:
    assert property ((!i_external_bus_request_n) [*4] |-> o_bus_grant_out) else $error("no grant");
  grant_state_a:
    assert property (o_bus_grant_out |-> o_processor_state_bit == 2'b11) else $error("state");
  vma_cycle_a:
    assert property ($rose(o_valid_address_qualifier) |->
      (o_valid_address_qualifier && o_address_oe) [*4]) else $error("vma short");
  irq_phase_a:
    assert property (o_irq_take |-> !o_quadrature_clock && !o_bus_enable_clock &&
      !$past(i_irq_mask)) else $error("irq take");
  fast_interrupt_request_n_cause_a:
    assert property (o_fast_interrupt_request_n_take |-> $past(i_instr_done) && !$past(i_fast_interrupt_request_n_mask))
      else $error("fast_interrupt_request_n take");
  unused_idle_a:
    assert property (o_last_cycle_marker == LAST_CYCLE_IDLE && o_standby_line == STANDBY_IDLE &&
      o_power_fail_line == POWER_FAIL_IDLE && o_parity_error_line == PARITY_ERROR_IDLE)
      else $error("unused line");
endmodule : backplane_bus_sva
`default_nettype wire

/* File: verif/plugin_memory_model.sv */
// plug-in memory module on the shared data lines
`timescale 1ns/100ps
`default_nettype none
module plugin_memory_model
  import backplane_bus_pkg::*;
(
  // bus side
  input wire logic i_clock,
  input wire logic i_enable,
  input wire logic i_vma,
  input wire logic i_rw,
  input wire logic [backplane_bus_pkg::ADDR_W-1:0] i_address,
  input wire logic [backplane_bus_pkg::DATA_W-1:0] i_data_line,
  // driven data
  output logic [backplane_bus_pkg::DATA_W-1:0] o_data_line,
  output logic o_data_line_oe
);
  logic [7:0] mem_r [256];
  logic [7:0] last_r = 8'h00;
  // drives only when selected for a read, in enable
  assign o_data_line_oe = i_vma && i_rw == RW_READ && i_enable;
  // floating lines show a changing pattern
  assign o_data_line = o_data_line_oe ? mem_r[i_address[7:0]] : ~last_r;
  always @(posedge i_clock)
  begin
    last_r <= o_data_line;
    if (i_vma && i_rw == RW_WRITE && i_enable)
      mem_r[i_address[7:0]] <= i_data_line;
  end
endmodule : plugin_memory_model
`default_nettype wire

/* File: verif/backplane_bus_signalling_tb.sv */
// self-checking bench for the backplane bus interface
`timescale 1ns/100ps
`default_nettype none
module backplane_bus_signalling_tb;
  import backplane_bus_pkg::*;
  logic i_clock = 0, i_nrst = 0, valid = 0, rdy = 0, done = 0;
  logic irqm = 1, firqm = 1, breq_n = 1, fast_interrupt_request_n_n = 1, irq_n = 1;
  bus_cmd_t cmd = '0;
  proc_state_t st = ST_RUN;
  logic cready, rvalid, irq_tk, fast_interrupt_request_n_tk, e, q, valid_address_qualifier, aoe, rw, rwoe, doe, gnt, moe, rel, mclk;
  logic [7:0] rdata, cpu_d, mem_d, line;
  logic [15:0] addr;
  logic [1:0] pst;
  logic [3:0] unused;
  int bad_count = 0, check_count = 0, cyc = 0;
  assign line = doe ? cpu_d : mem_d;
  backplane_bus_if u_backplane_bus_if (.i_clock, .i_nrst, .i_cmd_valid(valid), .i_cmd(cmd),
    .o_cmd_ready(cready), .o_rdata_valid(rvalid), .o_rdata(rdata), .i_rdata_ready(rdy),
    .i_core_state(st), .i_instr_done(done), .i_irq_mask(irqm), .i_fast_interrupt_request_n_mask(firqm),
    .o_irq_take(irq_tk), .o_fast_interrupt_request_n_take(fast_interrupt_request_n_tk), .o_bus_released(rel),
    .o_bus_enable_clock(e), .o_quadrature_clock(q), .o_free_running_memory_clock(mclk),
    .o_valid_address_qualifier(valid_address_qualifier), .o_address(addr), .o_address_oe(aoe),
    .o_read_write(rw), .o_read_write_oe(rwoe), .i_data_line(line), .o_data_line(cpu_d),
    .o_data_line_oe(doe), .i_external_bus_request_n(breq_n), .o_bus_grant_out(gnt),
    .o_processor_state_bit(pst), .i_fast_interrupt_request_n(fast_interrupt_request_n_n),
    .i_interrupt_request_n(irq_n), .o_last_cycle_marker(unused[0]),
    .o_standby_line(unused[1]), .o_power_fail_line(unused[2]),
    .o_parity_error_line(unused[3]));
  plugin_memory_model u_plugin_memory_model (.i_clock, .i_enable(e), .i_vma(valid_address_qualifier), .i_rw(rw),
    .i_address(addr), .i_data_line(line), .o_data_line(mem_d), .o_data_line_oe(moe));
  initial
  begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask : tick
  task automatic issue(input logic [15:0] a, input logic r, input logic [7:0] d);
    int n;
    n = 0;
    valid = 1;
    cmd = '{addr: a, rw: r, wdata: d};
    while (cready !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    tick(1);
    chk({n < 40, valid_address_qualifier, rw, addr}, {1'b1, 1'b1, r, a});
  endtask : issue
  task automatic pop(input logic [7:0] x);
    int n;
    n = 0;
    while (rvalid !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk({n < 40, rdata}, {1'b1, x});
    tick(1);
  endtask : pop
  task automatic t_idle();
    chk({unused, gnt, pst, rvalid}, {PARITY_ERROR_IDLE, POWER_FAIL_IDLE, STANDBY_IDLE,
      LAST_CYCLE_IDLE, 1'b0, ST_RUN, 1'b0});
  endtask : t_idle
  task automatic t_state();
    for (int i = 0; i < 4; i++)
    begin
      st = proc_state_t'(i);
      tick(3);
      chk(pst, i[1:0]);
    end
    st = ST_RUN;
  endtask : t_state
  task automatic t_buffer();
    int hit;
    issue(16'h0010, RW_WRITE, 8'h11);
    issue(16'h0011, RW_WRITE, 8'h22);
    issue(16'h0012, RW_WRITE, 8'h33);
    issue(16'h0010, RW_READ, 8'h00);
    issue(16'h0011, RW_READ, 8'h00);
    cmd = '{addr: 16'h0012, rw: RW_READ, wdata: 8'h00};
    hit = 0;
    repeat (16)
    begin
      tick(1);
      hit += (cready !== 1'b0);
    end
    chk(hit, 0);
    rdy = 1;
    pop(8'h11);
    pop(8'h22);
    issue(16'h0012, RW_READ, 8'h00);
    valid = 0;
    pop(8'h33);
    rdy = 0;
  endtask : t_buffer
  task automatic t_clocks();
    int n;
    n = 0;
    while ({q, e} !== 2'b10 && n < 8)
    begin
      tick(1);
      n++;
    end
    chk({n < 8, q, e, mclk}, {1'b1, 2'b10, 1'b0});
    tick(1);
    chk({q, e, mclk}, 3'b111);
    tick(1);
    chk({q, e, mclk}, 3'b011);
    tick(1);
    chk({q, e, mclk}, 3'b000);
  endtask : t_clocks
  task automatic t_grant();
    breq_n = 0;
    tick(4);
    chk({gnt, rel, aoe, rwoe, doe, pst, cready}, 8'b11000110);
    t_clocks();
    breq_n = 1;
    tick(4);
    chk({gnt, rel, aoe, rwoe, pst}, {4'b0011, ST_RUN});
  endtask : t_grant
  task automatic t_fast_interrupt_request_n();
    logic [2:0] cs [4];
    cs = '{3'b001, 3'b001, 3'b010, 3'b100};
    foreach (cs[i])
    begin
      {fast_interrupt_request_n_n, firqm} = cs[i][2:1];
      tick(3);
      chk(fast_interrupt_request_n_tk, 1'b0);
      done = 1;
      tick(1);
      chk(fast_interrupt_request_n_tk, cs[i][0]);
      done = 0;
    end
  endtask : t_fast_interrupt_request_n
  task automatic t_irq();
    int hit;
    irq_n = 0;
    irqm = 0;
    hit = 0;
    repeat (12)
    begin
      tick(1);
      hit += (irq_tk === 1'b1);
    end
    chk(hit >= 2, 1);
    irqm = 1;
    tick(2);
    hit = 0;
    repeat (12)
    begin
      tick(1);
      hit += (irq_tk === 1'b1);
    end
    chk(hit, 0);
    irq_n = 1;
  endtask : t_irq
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (doe === 1'b1 && moe === 1'b1)
      chk(1, 0);
    if (cyc == 3000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    tick(10);
    i_nrst = 1;
    t_idle();
    t_state();
    t_buffer();
    t_grant();
    t_fast_interrupt_request_n();
    t_irq();
    summarize();
  end
endmodule : backplane_bus_signalling_tb
bind backplane_bus_if backplane_bus_sva u_backplane_bus_sva (.i_clock, .i_nrst, .i_instr_done,
  .i_irq_mask, .i_fast_interrupt_request_n_mask, .i_external_bus_request_n, .o_irq_take, .o_fast_interrupt_request_n_take,
  .o_bus_enable_clock, .o_quadrature_clock, .o_free_running_memory_clock,
  .o_valid_address_qualifier, .o_address_oe, .o_read_write_oe, .o_data_line_oe,
  .o_bus_grant_out, .o_processor_state_bit, .o_last_cycle_marker, .o_standby_line,
  .o_power_fail_line, .o_parity_error_line);
`default_nettype wire
